/* File: core/pmc_core.sv */
// Privilege level, operating mode, stack select and bit-band control
// How it works
// - Handler mode only ever at privileged level
// - User-level guarded access raises a fault
// - Privileged level never raises access faults
// - Exceptions run in handler, otherwise thread
// - Thread mode runs privileged or user
// - Two stack pointers, exactly one active
// - Decode only 16/32-bit compressed set
// - Active-low reset pin holds block reset
// - Bit-band gives atomic single-bit SRAM access
// - Control bit 0 picks thread privilege
// - Control bit 1 picks active stack
// - Stack select reads zero in handler
`timescale 1ns/1ns
`default_nettype none
module pmc_core #(
  parameter int SPW     = 32,  // Stack pointer width
  parameter int DEPTH_W = 4,   // Exception nesting counter width
  parameter int SRAM_AW = 6    // Word address width of bit-band SRAM
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_external_reset_pin_n,
  input  wire logic                      i_exc_entry,
  input  wire logic                      i_exc_return,
  input  wire logic                      i_ctrl_wr,
  input  wire pmc_pkg::pmc_ctrl_t        i_ctrl_wdata,
  input  wire logic                      i_acc_valid,
  input  wire pmc_pkg::pmc_acc_t         i_acc_kind,
  input  wire logic                      i_insn_valid,
  input  wire logic                      i_insn_compact,
  input  wire logic [15:0]               i_insn_hw,
  input  wire logic                      i_sp_wr,
  input  wire logic [SPW-1:0]            i_sp_wdata,
  input  wire logic                      i_bb_valid,
  input  wire logic                      i_bb_write,
  input  wire logic [SRAM_AW+4:0]        i_bb_addr,
  input  wire logic                      i_bb_wbit,
  output logic                           o_int_reset,
  output pmc_pkg::pmc_exec_t             o_exec,
  output pmc_pkg::pmc_ctrl_t             o_ctrl,
  output logic [SPW-1:0]                 o_sp,
  output logic                           o_fault,
  output logic                           o_insn_len32,
  output logic                           o_bb_ready,
  output logic                           o_bb_done,
  output logic                           o_bb_rdata
);
  localparam int BBW = pmc_pkg::BB_BIT_W;

  typedef struct packed {
    logic [2:0]          pin_sync;
    logic                pin_lvl;
    pmc_pkg::pmc_ctrl_t  ctrl;
    logic [DEPTH_W-1:0]  depth;
    logic [SPW-1:0]      main_sp;
    logic [SPW-1:0]      proc_sp;
    logic                fault;
    logic                len32;
    pmc_pkg::pmc_bb_st_t bb_st;
    logic [SRAM_AW-1:0]  bb_word;
    logic [BBW-1:0]      bb_bit;
    logic                bb_we;
    logic                bb_wbit;
    logic                bb_done;
    logic                bb_rdata;
  } pmc_state_t;

  pmc_state_t st_reg;
  pmc_state_t st_next;
  logic       handler;
  logic       privileged;
  logic       psp_sel;
  logic       ram_en;
  logic       ram_we;
  logic [31:0] ram_rdata;
  logic [31:0] ram_wdata;

  // 32-bit encoding recognised from the first halfword
  function automatic logic is_wide(input logic [15:0] hw);
    logic [4:0] pfx;
    pfx = hw[pmc_pkg::INSN_PFX_MSB:pmc_pkg::INSN_PFX_LSB];
    return (pfx == pmc_pkg::INSN32_PFX_A) ||
           (pfx == pmc_pkg::INSN32_PFX_B) ||
           (pfx == pmc_pkg::INSN32_PFX_C);
  endfunction

  // Stack values keep the low bits clear so the pointer stays aligned
  function automatic logic [SPW-1:0] align_sp(input logic [SPW-1:0] v);
    return {v[SPW-1:pmc_pkg::SP_ZERO_BITS], {pmc_pkg::SP_ZERO_BITS{1'b0}}};
  endfunction

  // Derived execution state
  assign handler    = (st_reg.depth != '0);
  assign privileged = handler || !st_reg.ctrl.user;
  assign psp_sel    = !handler && st_reg.ctrl.spsel;

  // SRAM strobes come straight from the bit-band state
  assign ram_en    = (st_reg.bb_st == pmc_pkg::BB_READ) ||
                     (st_reg.bb_st == pmc_pkg::BB_WRITE);
  assign ram_we    = (st_reg.bb_st == pmc_pkg::BB_WRITE);
  // Only the addressed bit changes; the rest is written back as read
  always_comb begin
    ram_wdata = ram_rdata;
    ram_wdata[st_reg.bb_bit] = st_reg.bb_wbit;
  end

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.fault   = 1'b0;
    st_next.bb_done = 1'b0;
    // Pin filter: level moves only when sync stages two and three agree
    st_next.pin_sync = {st_reg.pin_sync[1:0], i_external_reset_pin_n};
    if (st_reg.pin_sync[1] == st_reg.pin_sync[2]) begin
      st_next.pin_lvl = st_reg.pin_sync[2];
    end
    if (!st_reg.pin_lvl) begin
      // Pin low: all but the synchroniser and the latched bit-band address, write flag and write data return to reset values
      st_next.ctrl     = '0;
      st_next.depth    = '0;
      st_next.main_sp  = '0;
      st_next.proc_sp  = '0;
      st_next.len32    = 1'b0;
      st_next.bb_st    = pmc_pkg::BB_IDLE;
      st_next.bb_rdata = 1'b0;
    end else begin
      // Exception nesting; entry wins if both arrive together
      if (i_exc_entry) begin
        if (st_reg.depth != '1) begin
          st_next.depth = st_reg.depth + 1'b1;
        end
      end else if (i_exc_return && handler) begin
        // Reaching zero drops to thread with current control bits
        st_next.depth = st_reg.depth - 1'b1;
      end
      // Control writes need privilege; a user attempt is a fault
      if (i_ctrl_wr) begin
        if (privileged) begin
          st_next.ctrl.user = i_ctrl_wdata.user;
          if (!handler) begin
            st_next.ctrl.spsel = i_ctrl_wdata.spsel;
          end
        end else begin
          st_next.fault = 1'b1;
        end
      end
      // Guarded accesses: blocked at user level, free when privileged
      if (i_acc_valid && (i_acc_kind != '0) && !privileged) begin
        st_next.fault = 1'b1;
      end
      // Legacy fixed-width state is not decoded at all
      if (i_insn_valid) begin
        if (!i_insn_compact) begin
          st_next.fault = 1'b1;
          st_next.len32 = 1'b0;
        end else begin
          st_next.len32 = is_wide(i_insn_hw);
        end
      end
      // Writes land in whichever pointer is active
      if (i_sp_wr) begin
        if (psp_sel) begin
          st_next.proc_sp = align_sp(i_sp_wdata);
        end else begin
          st_next.main_sp = align_sp(i_sp_wdata);
        end
      end
      // Bit-band read, then for a write put back the word with one bit changed
      case (st_reg.bb_st)
        pmc_pkg::BB_IDLE: begin
          if (i_bb_valid) begin
            st_next.bb_word = i_bb_addr[SRAM_AW+BBW-1:BBW];
            st_next.bb_bit  = i_bb_addr[BBW-1:0];
            st_next.bb_we   = i_bb_write;
            st_next.bb_wbit = i_bb_wbit;
            st_next.bb_st   = pmc_pkg::BB_READ;
          end
        end
        pmc_pkg::BB_READ: begin
          st_next.bb_st = pmc_pkg::BB_WAIT;
        end
        pmc_pkg::BB_WAIT: begin
          st_next.bb_rdata = ram_rdata[st_reg.bb_bit];
          if (st_reg.bb_we) begin
            st_next.bb_st = pmc_pkg::BB_WRITE;
          end else begin
            st_next.bb_done = 1'b1;
            st_next.bb_st   = pmc_pkg::BB_IDLE;
          end
        end
        pmc_pkg::BB_WRITE: begin
          st_next.bb_done = 1'b1;
          st_next.bb_st   = pmc_pkg::BB_IDLE;
        end
        default: begin
          st_next.bb_st = pmc_pkg::BB_IDLE;
        end
      endcase
    end
  end

  // State register; reset starts with the pin treated as low
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg          <= '0;
      st_reg.pin_sync <= pmc_pkg::PIN_SYNC_RST;
      st_reg.pin_lvl  <= pmc_pkg::PIN_LVL_RST;
      st_reg.bb_st    <= pmc_pkg::BB_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  pmc_sram #(
    .DW (32),
    .AW (SRAM_AW)
  ) u_sram (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_en      (ram_en),
    .i_we      (ram_we),
    .i_addr    (st_reg.bb_word),
    .i_wdata   (ram_wdata),
    .o_rdata   (ram_rdata)
  );

  // Outputs; the current pointer is a mux of two flops
  assign o_int_reset = !st_reg.pin_lvl;
  assign o_exec      = '{privileged: privileged, handler: handler,
                         psp_active: psp_sel};
  assign o_ctrl      = '{spsel: psp_sel, user: st_reg.ctrl.user};
  assign o_sp        = psp_sel ? st_reg.proc_sp : st_reg.main_sp;
  assign o_fault     = st_reg.fault;
  assign o_insn_len32 = st_reg.len32;
  assign o_bb_ready  = (st_reg.bb_st == pmc_pkg::BB_IDLE) && st_reg.pin_lvl;
  assign o_bb_done   = st_reg.bb_done;
  assign o_bb_rdata  = st_reg.bb_rdata;
endmodule // pmc_core
`default_nettype wire

/* File: core/pmc_pkg.sv */
// Shared types and constants for the privilege and mode control block
`default_nettype none
package pmc_pkg;
  // Mode control word bit positions
  localparam int CTRL_USER_BIT  = 0;
  localparam int CTRL_SPSEL_BIT = 1;
  localparam int CTRL_W         = 2;
  // Low stack pointer bits always read as zero (word aligned)
  localparam int SP_ZERO_BITS   = 2;
  // First-halfword prefixes that mark a 32-bit encoding
  localparam logic [4:0] INSN32_PFX_A = 5'h1D;
  localparam logic [4:0] INSN32_PFX_B = 5'h1E;
  localparam logic [4:0] INSN32_PFX_C = 5'h1F;
  localparam int INSN_PFX_MSB = 15;
  localparam int INSN_PFX_LSB = 11;
  // Bit-band alias: low bits of the alias word index pick the bit
  localparam int BB_BIT_W = 5;
  // Reset values
  localparam logic [2:0] PIN_SYNC_RST = 3'h0;
  localparam logic       PIN_LVL_RST  = 1'b0;

  // Mode control bits as software writes them
  typedef struct packed {
    logic spsel;   // 1: alternate (process) stack in thread mode
    logic user;    // 1: thread mode runs at user level
  } pmc_ctrl_t;

  // Kinds of guarded access requested by the executing instruction
  typedef struct packed {
    logic debug;
    logic config_reg;
    logic special_reg;
    logic restricted_insn;
  } pmc_acc_t;

  // Visible execution state
  typedef struct packed {
    logic privileged;
    logic handler;
    logic psp_active;
  } pmc_exec_t;

  typedef enum logic [1:0] {
    BB_IDLE,
    BB_READ,
    BB_WAIT,
    BB_WRITE
  } pmc_bb_st_t;
endpackage
`default_nettype wire

/* File: core/pmc_sram.sv */
// Small word memory with registered read data for bit-band access
`timescale 1ns/1ns
`default_nettype none
module pmc_sram #(
  parameter int DW = 32,
  parameter int AW = 6
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst,
  input  wire logic          i_en,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  // Array has no reset; contents are undefined until written
  always_ff @(posedge i_sys_clk) begin
    if (i_en && i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  // Read data held in a register until the next read
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= '0;
    end else if (i_en && !i_we) begin
      rdata_reg <= mem[i_addr];
    end
  end

  assign o_rdata = rdata_reg;
endmodule // pmc_sram
`default_nettype wire

/* File: testbench/pmc_chk.sv */
// Assertion checker for the privilege and mode control block
`timescale 1ns/1ns
`default_nettype none
module pmc_chk (
  input wire logic               i_sys_clk,
  input wire logic               i_rst,
  input wire logic               i_external_reset_pin_n,
  input wire logic               i_acc_valid,
  input wire pmc_pkg::pmc_acc_t  i_acc_kind,
  input wire logic               i_insn_valid,
  input wire logic               i_insn_compact,
  input wire logic [15:0]        i_insn_hw,
  input wire logic               i_bb_valid,
  input wire logic               i_bb_write,
  input wire logic               o_int_reset,
  input wire pmc_pkg::pmc_exec_t o_exec,
  input wire pmc_pkg::pmc_ctrl_t o_ctrl,
  input wire logic               o_fault,
  input wire logic               o_insn_len32,
  input wire logic               o_bb_ready,
  input wire logic               o_bb_done
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Prefix decode kept apart so $past sees a plain signal
  logic is32;
  assign is32 = i_insn_hw[15:11] >= pmc_pkg::INSN32_PFX_A;
  // State legality
  a_handler_priv: assert property (o_exec.handler |-> o_exec.privileged)
    else $error("handler state seen at user level");
  a_handler_main: assert property (o_exec.handler |->
    !o_ctrl.spsel && !o_exec.psp_active) else $error("alt stack in handler");
  a_thread_level: assert property (!o_exec.handler |->
    o_exec.privileged == !o_ctrl.user) else $error("thread level wrong");
  a_thread_stack: assert property (!o_exec.handler |->
    o_exec.psp_active == o_ctrl.spsel) else $error("thread stack wrong");
  // Access guarding
  a_user_fault: assert property (i_acc_valid && i_acc_kind != 4'h0 &&
    !o_exec.privileged && !o_int_reset |=> o_fault) else $error("no fault");
  a_priv_nofault: assert property (i_acc_valid && o_exec.privileged &&
    !(i_insn_valid && !i_insn_compact) |=> !o_fault) else $error("bad fault");
  a_legacy_fault: assert property (i_insn_valid && !i_insn_compact &&
    !o_int_reset |=> o_fault && !o_insn_len32) else $error("legacy taken");
  a_insn_len: assert property (i_insn_valid && i_insn_compact &&
    !o_int_reset |=> o_insn_len32 == $past(is32)) else $error("length wrong");
  // Bit-band timing, ready drops while the word is modified
  a_bb_write: assert property (i_bb_valid && o_bb_ready &&
    i_bb_write |=> !o_bb_ready[*3] ##1 o_bb_done)
    else $error("bit write timing");
  a_bb_read: assert property (i_bb_valid && o_bb_ready &&
    !i_bb_write |=> !o_bb_ready[*2] ##1 o_bb_done)
    else $error("bit read timing");
  a_pin_reset: assert property (!i_external_reset_pin_n[*5] |->
    o_int_reset) else $error("pin low without internal reset");
  c_handler: cover property (o_exec.handler);
  c_fault: cover property (o_fault && !o_exec.privileged);
  c_bb_done: cover property (o_bb_done);
endmodule // pmc_chk
`default_nettype wire

/* File: testbench/pmc_core_bench.sv */
// Self-checking bench for the privilege and mode control block
`timescale 1ns/1ns
`default_nettype none
module pmc_core_bench;
  // Op 0 acc, 1 insn, 2 legacy, 3 ctrl, 4 entry, 5 return, 6 sp, F idle
  typedef struct packed {
    logic [3:0]  op;
    logic [15:0] d;
    logic [4:0]  ex;  // privileged, handler, psp, fault, len32
    logic [15:0] sp;
  } pmc_row_t;
  logic               i_sys_clk = 1'h0;
  logic               i_rst     = 1'h1;
  logic               pin_n     = 1'h1;
  logic               entry, ret, ctrl_wr, acc_v, insn_v, compact, sp_wr;
  logic               bb_v, bb_w, bb_b, int_rst, fault, len32;
  logic               bb_rdy, bb_done, bb_rd;
  logic [15:0]        hw;
  logic [31:0]        sp_wd, sp;
  logic [10:0]        bb_a;
  pmc_pkg::pmc_ctrl_t ctrl_wd, ctrl;
  pmc_pkg::pmc_acc_t  acc_kind;
  pmc_pkg::pmc_exec_t exec;
  int                 mismatches = 0;
  int                 total_checks = 0;
  int                 cycles = 0;
  int                 n;
  pmc_row_t rows [0:19] = '{
    '{4'h0,16'h0001,5'h10,16'h0000}, '{4'h1,16'hE800,5'h11,16'h0000},
    '{4'h1,16'hE000,5'h10,16'h0000}, '{4'h1,16'hF800,5'h11,16'h0000},
    '{4'h2,16'hF800,5'h12,16'h0000}, '{4'h3,16'h0002,5'h14,16'h0000},
    '{4'h4,16'h0000,5'h18,16'h0000}, '{4'h3,16'h0003,5'h18,16'h0000},
    '{4'h5,16'h0000,5'h04,16'h0000}, '{4'h0,16'h0008,5'h06,16'h0000},
    '{4'h0,16'h0004,5'h06,16'h0000}, '{4'h3,16'h0000,5'h06,16'h0000},
    '{4'h0,16'h0000,5'h04,16'h0000}, '{4'h6,16'h1003,5'h04,16'h1000},
    '{4'h4,16'h0000,5'h18,16'h0000}, '{4'h6,16'h2002,5'h18,16'h2000},
    '{4'h4,16'h0000,5'h18,16'h2000}, '{4'h5,16'h0000,5'h18,16'h2000},
    '{4'h5,16'h0000,5'h04,16'h1000}, '{4'h0,16'h0002,5'h06,16'h1000}};

  pmc_core pmc_core_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_external_reset_pin_n(pin_n), .i_exc_entry(entry), .i_exc_return(ret),
    .i_ctrl_wr(ctrl_wr), .i_ctrl_wdata(ctrl_wd), .i_acc_valid(acc_v),
    .i_acc_kind(acc_kind), .i_insn_valid(insn_v), .i_insn_compact(compact),
    .i_insn_hw(hw), .i_sp_wr(sp_wr), .i_sp_wdata(sp_wd), .i_bb_valid(bb_v),
    .i_bb_write(bb_w), .i_bb_addr(bb_a), .i_bb_wbit(bb_b),
    .o_int_reset(int_rst), .o_exec(exec), .o_ctrl(ctrl), .o_sp(sp),
    .o_fault(fault), .o_insn_len32(len32), .o_bb_ready(bb_rdy),
    .o_bb_done(bb_done), .o_bb_rdata(bb_rd));

  // 10 MHz clock
  always #50 i_sys_clk = ~i_sys_clk;

  // Hang guard, well beyond the hundred or so cycles the tests need
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobes for one op; op F lowers them all
  task automatic drive(input pmc_row_t r);
    acc_v    <= r.op == 4'h0;
    insn_v   <= r.op == 4'h1 || r.op == 4'h2;
    compact  <= r.op == 4'h1;
    ctrl_wr  <= r.op == 4'h3;
    entry    <= r.op == 4'h4;
    ret      <= r.op == 4'h5;
    sp_wr    <= r.op == 4'h6;
    acc_kind <= pmc_pkg::pmc_acc_t'(r.d[3:0]);
    ctrl_wd  <= pmc_pkg::pmc_ctrl_t'(r.d[1:0]);
    hw       <= r.d;
    sp_wd    <= {16'h0000, r.d};
  endtask

  // One bit-band op; ready is idle-high, so the next edge takes it
  task automatic bb(input logic w, input logic [10:0] a, input logic b);
    @(posedge i_sys_clk);
    bb_v <= 1'h1;
    bb_w <= w;
    bb_a <= a;
    bb_b <= b;
    @(posedge i_sys_clk);
    bb_v <= 1'h0;
    n = 0;
    @(negedge i_sys_clk);
    while (bb_done !== 1'h1 && n < 8) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(32'(bb_done), 32'h1);
  endtask

  task automatic wait_out;
    n = 0;
    while (int_rst !== 1'h0 && n < 20) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    drive('{4'hF,16'h0000,5'h00,16'h0000});
    bb_v <= 1'h0;
    bb_w <= 1'h0;
    bb_a <= 11'h000;
    bb_b <= 1'h0;
    repeat (16) @(posedge i_sys_clk);
    chk(32'({int_rst, exec}), 32'h0000000C);
    i_rst <= 1'h0;
    wait_out();
    chk(32'(int_rst), 32'h0);
    $display("reset test done");
    // Event table, one op per row
    foreach (rows[i]) begin
      @(posedge i_sys_clk);
      drive(rows[i]);
      @(posedge i_sys_clk);
      drive('{4'hF,16'h0000,5'h00,16'h0000});
      @(negedge i_sys_clk);
      chk(32'(exec), 32'(rows[i].ex[4:2]));
      chk(32'({fault, len32}), 32'(rows[i].ex[1:0]));
      chk(sp, {16'h0000, rows[i].sp});
    end
    $display("mode table test done");
    // Set, clear and neighbour bits of one SRAM word
    bb(1'h1, 11'h045, 1'h1);
    bb(1'h1, 11'h045, 1'h0);
    chk(32'(bb_rd), 32'h1);
    bb(1'h1, 11'h046, 1'h1);
    bb(1'h0, 11'h045, 1'h0);
    chk(32'(bb_rd), 32'h0);
    bb(1'h0, 11'h046, 1'h0);
    chk(32'(bb_rd), 32'h1);
    $display("bit-band test done");
    // Pin reset from user thread state clears the mode state
    @(posedge i_sys_clk);
    pin_n <= 1'h0;
    repeat (6) @(negedge i_sys_clk);
    chk(32'({int_rst, bb_rdy}), 32'h2);
    @(posedge i_sys_clk);
    pin_n <= 1'h1;
    wait_out();
    chk(32'({int_rst, exec, ctrl}), 32'h10);
    $display("pin reset test done");
    // Return in thread is ignored; entry beats a same-cycle return
    @(posedge i_sys_clk);
    ret <= 1'h1;
    @(posedge i_sys_clk);
    ret <= 1'h0;
    @(negedge i_sys_clk);
    chk(32'(exec), 32'h4);
    @(posedge i_sys_clk);
    entry <= 1'h1;
    ret   <= 1'h1;
    @(posedge i_sys_clk);
    entry <= 1'h0;
    ret   <= 1'h0;
    @(negedge i_sys_clk);
    chk(32'(exec), 32'h6);
    $display("nesting edge test done");
    test_done();
  end
endmodule // pmc_core_bench

bind pmc_core pmc_chk pmc_chk_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_external_reset_pin_n(i_external_reset_pin_n), .i_acc_valid(i_acc_valid),
  .i_acc_kind(i_acc_kind), .i_insn_valid(i_insn_valid),
  .i_insn_compact(i_insn_compact), .i_insn_hw(i_insn_hw),
  .i_bb_valid(i_bb_valid), .i_bb_write(i_bb_write),
  .o_int_reset(o_int_reset), .o_exec(o_exec), .o_ctrl(o_ctrl),
  .o_fault(o_fault), .o_insn_len32(o_insn_len32), .o_bb_ready(o_bb_ready),
  .o_bb_done(o_bb_done));
`default_nettype wire
